// [hw/pin_output_mux.sv]
// Registered output selector that routes one peripheral output onto each remappable pin.
// Assumes select codes come from registers on the same clock as the peripherals.
`timescale 1ns/1ps
module pin_output_mux
  import remap_pkg::*;
(
  input  wire logic                            clk_in,
  input  wire logic                            sys_rst_in,
  input  wire logic [NUM_PINS-1:0][SEL_W-1:0]  sel_in,
  input  wire periph_out_t                     periph_in,
  output logic      [NUM_PINS-1:0]             pin_out,
  output logic      [NUM_PINS-1:0]             pin_oe_out
);

  // Returns {enable, level}; reserved and unknown codes leave the pin undriven
  function automatic logic [1:0] route(input int grp, input logic [SEL_W-1:0] code,
                                       input periph_out_t p);
    logic [1:0] r;
    r = 2'h0;
    case (grp)
      0: case (code)
        OSEL_G0_UART1_TRANSMIT:  r = {1'b1, p.uart1_transmit};
        OSEL_G0_UART2_REQUEST_TO_SEND: r = {1'b1, p.uart2_request_to_send};
        OSEL_G0_S1SS:  r = {1'b1, p.spi1_slave_select};
        OSEL_G0_CMP2:  r = {1'b1, p.comparator2_output};
        default:       r = 2'h0;
      endcase
      1: case (code)
        OSEL_G12_S1DO: r = {1'b1, p.spi1_data_out};
        OSEL_G12_S2DO: r = {1'b1, p.spi2_data_out};
        OSEL_G1_OCMP2: r = {1'b1, p.output_compare_2};
        OSEL_G1_CMP3:  r = {1'b1, p.comparator3_output};
        default:       r = 2'h0;
      endcase
      2: case (code)
        OSEL_G12_S1DO:  r = {1'b1, p.spi1_data_out};
        OSEL_G12_S2DO:  r = {1'b1, p.spi2_data_out};
        OSEL_G2_OCMP4:  r = {1'b1, p.output_compare_4};
        OSEL_G2_OCMP5:  r = {1'b1, p.output_compare_5};
        OSEL_G2_REFCLK: r = {1'b1, p.reference_clock_output};
        default:        r = 2'h0;
      endcase
      default: case (code)
        OSEL_G3_S2SS:  r = {1'b1, p.spi2_slave_select};
        OSEL_G3_OCMP3: r = {1'b1, p.output_compare_3};
        OSEL_G3_CMP1:  r = {1'b1, p.comparator1_output};
        default:       r = 2'h0;
      endcase
    endcase
    return r;
  endfunction

  // One registered selector per pin; costs a cycle of latency but keeps pins glitch free
  for (genvar n = 0; n < NUM_PINS; n++) begin : g_pin
    logic [1:0] sel_d;
    always_comb begin
      sel_d = route(n / PINS_PER_GROUP, sel_in[n], periph_in);
    end
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        pin_oe_out[n] <= 1'b0;
        pin_out[n]    <= 1'b0;
      end else begin
        pin_oe_out[n] <= sel_d[1];
        pin_out[n]    <= sel_d[0];
      end
    end
  end

  a_null_code_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sel_in[0] == OSEL_NONE |=> !pin_oe_out[0] && !pin_out[0])
    else $error("pin driven with null select code");

  a_group0_uart: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sel_in[1] == OSEL_G0_UART1_TRANSMIT |=> pin_oe_out[1] && pin_out[1] == $past(periph_in.uart1_transmit))
    else $error("uart1 transmit not routed to group 0 pin");

  a_group2_refclk: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sel_in[2*PINS_PER_GROUP] == OSEL_G2_REFCLK
      |=> pin_oe_out[2*PINS_PER_GROUP]
          && pin_out[2*PINS_PER_GROUP] == $past(periph_in.reference_clock_output))
    else $error("reference clock not routed to group 2 pin");

endmodule // pin_output_mux

// [hw/remap_lock_and_output_select.sv]
// APB register block for remappable pin select: lock, unlock keys, pin and input selects.
// Assumes an APB master on clk_in, peripheral outputs on clk_in, pin inputs asynchronous.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module remap_lock_and_output_select
  import remap_pkg::*;
#(
  parameter logic [31:0] UNLOCK_KEY1 = 32'h1234_5678, // Arbitrary key value
  parameter logic [31:0] UNLOCK_KEY2 = 32'h8765_4321  // Arbitrary key value
) (
  input  wire logic                   clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [ADDR_W-1:0]      paddr_in,
  input  wire logic [31:0]            pwdata_in,
  input  wire logic [3:0]             pstrb_in,
  output logic      [31:0]            prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  input  wire logic                   cfg_single_session_in,
  input  wire periph_out_t            periph_in,
  input  wire logic [NUM_PINS-1:0]    pin_in,
  output logic      [NUM_PINS-1:0]    pin_out,
  output logic      [NUM_PINS-1:0]    pin_oe_out,
  output logic      [NUM_INSEL-1:0]   periph_in_out,
  output logic      [31:0]            porta_analog_out,
  output logic      [31:0]            porta_dir_out,
  output logic                        map_lock_out,
  output logic                        single_session_out
);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // State
  logic                              pready_q;
  logic                              pslverr_q;
  logic [31:0]                       prdata_q;
  logic                              map_lock_q;
  logic                              single_session_q;
  logic [1:0]                        cap_cnt_q;
  logic                              cfg_meta_q;
  logic                              cfg_sync_q;
  unlock_state_t                     unlock_q;
  logic [NUM_PINS-1:0][SEL_W-1:0]    outsel_q;
  logic [NUM_INSEL-1:0][SEL_W-1:0]   insel_q;
  logic [31:0]                       porta_ansel_q;
  logic [31:0]                       porta_dir_q;
  logic [NUM_PINS-1:0]               pin_meta_q;
  logic [NUM_PINS-1:0]               pin_sync_q;
  logic [NUM_INSEL-1:0]              periph_in_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic                              access;
  logic                              commit;
  logic                              wr_commit;
  logic                              hit_cfg;
  logic                              hit_key;
  logic                              hit_dcfg;
  logic                              hit_ansel;
  logic                              hit_dir;
  logic                              hit_out;
  logic                              hit_in;
  logic [4:0]                        word_idx;
  logic [31:0]                       rdata_d;
  logic                              err_d;

  // Access phase; the answer is registered so it comes one cycle after penable rises
  assign access    = psel_in && penable_in;
  assign commit    = access && pready_q;
  assign wr_commit = commit && pwrite_in;

  // Word-aligned decode; the low two address bits are ignored
  assign word_idx  = paddr_in[REGION_LSB-1:2];
  assign hit_cfg   = paddr_in[ADDR_W-1:2] == ADDR_CFG_CTRL[ADDR_W-1:2];
  assign hit_key   = paddr_in[ADDR_W-1:2] == ADDR_UNLOCK_KEY[ADDR_W-1:2];
  assign hit_dcfg  = paddr_in[ADDR_W-1:2] == ADDR_DEV_CFG3[ADDR_W-1:2];
  assign hit_ansel = paddr_in[ADDR_W-1:2] == ADDR_PORTA_ANSEL[ADDR_W-1:2];
  assign hit_dir   = paddr_in[ADDR_W-1:2] == ADDR_PORTA_DIR[ADDR_W-1:2];
  assign hit_out   = paddr_in[ADDR_W-1:REGION_LSB] == ADDR_OUTSEL_BASE[ADDR_W-1:REGION_LSB];
  assign hit_in    = (paddr_in[ADDR_W-1:REGION_LSB] == ADDR_INSEL_BASE[ADDR_W-1:REGION_LSB])
                     && (32'(word_idx) < NUM_INSEL);

  // Read data and error flag; unmapped addresses answer zero with an error
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    if (hit_cfg) begin
      rdata_d[MAP_LOCK_POS] = map_lock_q;
    end else if (hit_key) begin
      rdata_d = 32'h0000_0000;                  // Keys never read back
    end else if (hit_dcfg) begin
      rdata_d[SINGLE_SESSION_POS] = single_session_q;
    end else if (hit_ansel) begin
      rdata_d = porta_ansel_q;
    end else if (hit_dir) begin
      rdata_d = porta_dir_q;
    end else if (hit_out) begin
      rdata_d[SEL_W-1:0] = outsel_q[word_idx];
    end else if (hit_in) begin
      rdata_d[SEL_W-1:0] = insel_q[word_idx];
    end else begin
      err_d = 1'b1;
    end
  end

  // One wait state per transfer; pready drops right after the completing edge
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= access && !pready_q;
      if (access && !pready_q) begin
        pslverr_q <= err_d;                     // Locked mapping writes keep no error
        prdata_q  <= pwrite_in ? 32'h0000_0000 : rdata_d;
      end else if (commit) begin
        pslverr_q <= 1'b0;
        prdata_q  <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Configuration word capture
  // The strap passes two flops, then is caught once after reset release
  always_ff @(posedge clk_in) begin
    cfg_meta_q <= cfg_single_session_in;
    cfg_sync_q <= cfg_meta_q;
  end

  // Defaults to set so an unprogrammed word restricts to one session
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cap_cnt_q        <= 2'h0;
      single_session_q <= 1'b1;
    end else if (cap_cnt_q != CAPTURE_DELAY) begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q + 2'h1 == CAPTURE_DELAY) begin
        single_session_q <= cfg_sync_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Unlock sequence and map lock
  // Two key writes in consecutive bus writes arm one change of the lock bit, unless a single-session lock is already set
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      unlock_q <= UNL_IDLE;
    end else if (wr_commit) begin
      case (unlock_q)
        UNL_IDLE: begin
          unlock_q <= (hit_key && pwdata_in == UNLOCK_KEY1) ? UNL_KEY1_SEEN : UNL_IDLE;
        end
        UNL_KEY1_SEEN: begin
          if (hit_key && pwdata_in == UNLOCK_KEY2 && !(single_session_q && map_lock_q)) begin
            unlock_q <= UNL_ARMED;
          end else if (hit_key && pwdata_in == UNLOCK_KEY1) begin
            unlock_q <= UNL_KEY1_SEEN;
          end else begin
            unlock_q <= UNL_IDLE;
          end
        end
        UNL_ARMED: begin
          unlock_q <= UNL_IDLE;                 // Any write consumes the arming
        end
        default: begin
          unlock_q <= UNL_IDLE;
        end
      endcase
    end
  end

  // Lock clears at reset or by an armed clear write; a sealed single-session lock ignores clears
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      map_lock_q <= 1'b0;
    end else if (wr_commit && hit_cfg && unlock_q == UNL_ARMED && pstrb_in[LOCK_BYTE]) begin
      if (pwdata_in[MAP_LOCK_POS]) begin
        map_lock_q <= 1'b1;
      end else if (!(single_session_q && map_lock_q)) begin
        map_lock_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Mapping registers
  // Lock is the registered value, so a write in the locking cycle still sees it open
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      outsel_q <= '0;
    end else if (wr_commit && hit_out && !map_lock_q && pstrb_in[0]) begin
      outsel_q[word_idx] <= pwdata_in[SEL_W-1:0];
    end
  end

  // Input selects share the same lock
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      insel_q <= '0;
    end else if (wr_commit && hit_in && !map_lock_q && pstrb_in[0]) begin
      insel_q[word_idx] <= pwdata_in[SEL_W-1:0];
    end
  end

  // Port A registers are not under the map lock
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      porta_ansel_q <= PORTA_ANSEL_RESET;
      porta_dir_q   <= PORTA_DIR_RESET;
    end else if (wr_commit) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb_in[b] && hit_ansel) begin
          porta_ansel_q[b*8 +: 8] <= pwdata_in[b*8 +: 8] & PORTA_ANSEL_MASK[b*8 +: 8];
        end
        if (pstrb_in[b] && hit_dir) begin
          porta_dir_q[b*8 +: 8] <= pwdata_in[b*8 +: 8] & PORTA_DIR_MASK[b*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Input routing
  // Pins are asynchronous: two flops before any select reads them
  always_ff @(posedge clk_in) begin
    pin_meta_q <= pin_in;
    pin_sync_q <= pin_meta_q;
  end

  // A code beyond the group size selects nothing and feeds a low level
  for (genvar k = 0; k < NUM_INSEL; k++) begin : g_in
    logic sel_bit;
    always_comb begin
      sel_bit = 1'b0;
      if (32'(insel_q[k]) < PINS_PER_GROUP) begin
        sel_bit = pin_sync_q[32'(IN_GROUP_OF[k]) * PINS_PER_GROUP + 32'(insel_q[k])];
      end
    end
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        periph_in_q[k] <= 1'b0;
      end else begin
        periph_in_q[k] <= sel_bit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Output routing
  pin_output_mux u_out_mux (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .sel_in     (outsel_q),
    .periph_in  (periph_in),
    .pin_out    (pin_out),
    .pin_oe_out (pin_oe_out)
  );

  // Outputs straight from flops
  assign prdata_out         = prdata_q;
  assign pready_out         = pready_q;
  assign pslverr_out        = pslverr_q;
  assign periph_in_out      = periph_in_q;
  assign porta_analog_out   = porta_ansel_q;
  assign porta_dir_out      = porta_dir_q;
  assign map_lock_out       = map_lock_q;
  assign single_session_out = single_session_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_access_start;
    psel_in && penable_in && !pready_q;
  endsequence

  sequence s_one_wait_answer;
    pready_q ##1 !pready_q;
  endsequence

  a_apb_one_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_access_start |=> s_one_wait_answer)
    else $error("answer not given after exactly one wait state");

  a_locked_outsel_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_commit && (hit_out || hit_in) && map_lock_q |=> $stable(outsel_q) && $stable(insel_q))
    else $error("mapping register changed while locked");

  a_locked_no_error: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    commit && (hit_out || hit_in) |-> !pslverr_q)
    else $error("mapping access answered with an error");

  a_open_write_lands: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_commit && hit_out && !map_lock_q && pstrb_in[0]
      |=> outsel_q[$past(word_idx)] == $past(pwdata_in[SEL_W-1:0]))
    else $error("unlocked output select write lost");

  a_lock_needs_keys: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$stable(map_lock_q) |-> $past(unlock_q) == UNL_ARMED && $past(wr_commit && hit_cfg))
    else $error("lock bit changed without unlock sequence");

  a_one_way_lock: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    single_session_q && map_lock_q |=> map_lock_q)
    else $error("single-session lock was cleared");

  a_sealed_no_arm: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    single_session_q && map_lock_q |-> unlock_q != UNL_ARMED)
    else $error("unlock armed while sealed");

  a_reset_clears: assert property (@(posedge clk_in)
    sys_rst_in |=> !map_lock_q && outsel_q == '0 && single_session_q)
    else $error("reset left lock, selects or session bit wrong");

  a_in_route: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    insel_q[0] == SEL_RESET |=> periph_in_q[0] == $past(pin_sync_q[0]))
    else $error("input select did not route its pin");

endmodule // remap_lock_and_output_select

// [hw/remap_pkg.sv]
// Constants, field layouts and carrier types for the remap lock and pin select block.
// Assumes a single 40 MHz system clock domain and an APB register port.
package remap_pkg;

  // Structure of the pin map
  localparam int NUM_GROUPS     = 4;
  localparam int PINS_PER_GROUP = 8;
  localparam int NUM_PINS       = NUM_GROUPS * PINS_PER_GROUP;
  localparam int NUM_INSEL      = 23;
  localparam int SEL_W          = 4;
  localparam int ADDR_W         = 12;
  localparam int REGION_LSB     = 7;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CFG_CTRL    = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK_KEY  = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_DEV_CFG3    = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_PORTA_ANSEL = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_PORTA_DIR   = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_OUTSEL_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] ADDR_INSEL_BASE  = 12'h200;

  // Field positions
  localparam int MAP_LOCK_POS       = 13;
  localparam int SINGLE_SESSION_POS = 29;
  localparam int LOCK_BYTE          = 1;

  // Reset values and writable masks of the port A registers
  localparam logic [31:0] PORTA_ANSEL_RESET = 32'h0000_0003;
  localparam logic [31:0] PORTA_ANSEL_MASK  = 32'h0000_0003;
  localparam logic [31:0] PORTA_DIR_RESET   = 32'h0000_079f;
  localparam logic [31:0] PORTA_DIR_MASK    = 32'h0000_079f;
  localparam logic [SEL_W-1:0] SEL_RESET    = 4'h0;

  // Output select codes per pin group
  localparam logic [SEL_W-1:0] OSEL_NONE        = 4'h0;
  localparam logic [SEL_W-1:0] OSEL_G0_UART1_TRANSMIT     = 4'h1;
  localparam logic [SEL_W-1:0] OSEL_G0_UART2_REQUEST_TO_SEND    = 4'h2;
  localparam logic [SEL_W-1:0] OSEL_G0_S1SS     = 4'h3;
  localparam logic [SEL_W-1:0] OSEL_G0_CMP2     = 4'h7;
  localparam logic [SEL_W-1:0] OSEL_G12_S1DO    = 4'h3;
  localparam logic [SEL_W-1:0] OSEL_G12_S2DO    = 4'h4;
  localparam logic [SEL_W-1:0] OSEL_G1_OCMP2    = 4'h5;
  localparam logic [SEL_W-1:0] OSEL_G1_CMP3     = 4'h7;
  localparam logic [SEL_W-1:0] OSEL_G2_OCMP4    = 4'h5;
  localparam logic [SEL_W-1:0] OSEL_G2_OCMP5    = 4'h6;
  localparam logic [SEL_W-1:0] OSEL_G2_REFCLK   = 4'h7;
  localparam logic [SEL_W-1:0] OSEL_G3_S2SS     = 4'h4;
  localparam logic [SEL_W-1:0] OSEL_G3_OCMP3    = 4'h5;
  localparam logic [SEL_W-1:0] OSEL_G3_CMP1     = 4'h7;

  // Pin group that each peripheral input select chooses from
  localparam logic [1:0] IN_GROUP_OF [NUM_INSEL] = '{
    2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
    2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h3, 2'h3, 2'h3, 2'h3, 2'h3};

  // Start-up capture of the configuration word, in cycles after reset release
  localparam logic [1:0] CAPTURE_DELAY = 2'h2;

  // Remappable peripheral outputs
  typedef struct packed {
    logic uart1_transmit;
    logic uart2_request_to_send;
    logic spi1_slave_select;
    logic spi2_slave_select;
    logic spi1_data_out;
    logic spi2_data_out;
    logic output_compare_2;
    logic output_compare_3;
    logic output_compare_4;
    logic output_compare_5;
    logic comparator1_output;
    logic comparator2_output;
    logic comparator3_output;
    logic reference_clock_output;
  } periph_out_t;

  // Unlock key sequence progress
  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_KEY1_SEEN,
    UNL_ARMED
  } unlock_state_t;

endpackage

// [verification/periph_model.sv]
// Partner model: the on-chip peripheral outputs feeding the pin selector.
// Assumes the bench sets the levels; they launch on clk_in like real peripherals.
`timescale 1ns/1ps
module periph_model
  import remap_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic [13:0] lvl_in,
  output periph_out_t      periph_out
);
  // Registered so levels move only on the system clock, as on chip
  always_ff @(posedge clk_in) periph_out <= periph_out_t'(lvl_in);
endmodule // periph_model

// [verification/testbench.sv]
// Self-checking bench: reset values, output routing per group, lock and sealing.
// Assumes a 40 MHz clock and an APB master in this module.
`timescale 1ns/1ps
module testbench
  import remap_pkg::*;
;
  logic        clk_in = 0, rst = 1, psel = 0, pen = 0, pwr = 0, serr, rdy, lock;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, rd, prd, pout, poe;
  logic [13:0] lvl = 0;
  logic        perr;
  logic [31:0] pin = 0, pao, pdo;
  logic [22:0] pio;
  logic        ss = 1, ssq;
  periph_out_t pv;
  int          err_total = 0, checks_done = 0;
  int gp[16] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 2, 3, 3, 3};
  int cd[16] = '{2, 1, 3, 7, 3, 4, 5, 7, 7, 3, 4, 5, 6, 4, 5, 7};
  int bt[16] = '{12, 13, 11, 2, 9, 8, 7, 1, 0, 9, 8, 5, 4, 10, 6, 3};

  periph_model i_periph_model (.clk_in, .lvl_in(lvl), .periph_out(pv));
  remap_lock_and_output_select #(.UNLOCK_KEY1(32'h1234_5678), .UNLOCK_KEY2(32'h8765_4321))
    i_remap_lock_and_output_select (.clk_in, .sys_rst_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(4'hf),
    .prdata_out(rd), .pready_out(rdy), .pslverr_out(serr), .cfg_single_session_in(ss),
    .periph_in(pv), .pin_in(pin), .pin_out(pout), .pin_oe_out(poe), .periph_in_out(pio),
    .porta_analog_out(pao), .porta_dir_out(pdo), .map_lock_out(lock),
    .single_session_out(ssq));

  // Clock; a hang is cut short after about 4000 cycles
  initial forever #12.5 clk_in = ~clk_in;
  initial begin
    #100000;
    err_total++;
    print_verdict;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is sampled high, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_in) pen <= 1;
    do @(posedge clk_in); while (rdy !== 1'b1);
    prd = rd;
    perr = serr;
    psel <= 0;
    pen <= 0;
    @(posedge clk_in);
  endtask
  // Unlock key pair, then the lock write itself
  task automatic set_lock(input logic v);
    apb(1, 12'h004, 32'h1234_5678);
    apb(1, 12'h004, 32'h8765_4321);
    apb(1, 12'h000, {18'h0, v, 13'h0});
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(0, 12'h010, 0);
    chk("analog", 32'h3, prd);
    apb(0, 12'h014, 0);
    chk("dir", 32'h79f, prd);
    apb(0, 12'h008, 0);
    chk("cfg3_bit29", 32'h1, {31'h0, prd[29]});
    apb(0, 12'h104, 0);
    chk("outsel1", 32'h0, prd);
    chk("pin_oe", 32'h0, poe);
    chk("analog_out", 32'h3, pao);
    apb(1, 12'h014, 32'h0);
    apb(0, 12'h014, 0);
    chk("dir_write", 32'h0, prd);
    chk("dir_out", 32'h0, pdo);
    $display("test reset done");
  endtask
  task automatic t_route;
    int p;
    for (int j = 0; j < 16; j++) begin
      p = gp[j] * 8 + j % 8;
      apb(1, 12'h100 + 12'(4 * p), 32'(cd[j]));
      for (int v = 0; v < 2; v++) begin
        lvl <= v ? 14'(1 << bt[j]) : ~14'(1 << bt[j]);
        repeat (3) @(posedge clk_in);
        chk("route", 32'(v), {31'h0, pout[p]});
        chk("oe", 32'h1, {31'h0, poe[p]});
      end
      apb(1, 12'h100 + 12'(4 * p), 0);
      @(posedge clk_in);
      chk("no_connect", 32'h0, {31'h0, poe[p]});
    end
    lvl <= 14'h3fff;
    apb(1, 12'h130, 32'h1);
    apb(1, 12'h100, 32'h8);
    repeat (3) @(posedge clk_in);
    chk("reserved_g1", 32'h0, {31'h0, poe[12]});
    chk("reserved_g0", 32'h0, {31'h0, poe[0]});
    $display("test route done");
  endtask
  task automatic t_input;
    pin <= 32'hffff_ffff;
    repeat (4) @(posedge clk_in);
    chk("in_default", 32'h1, {31'h0, pio[0]});
    apb(1, 12'h200, 32'h3);
    apb(1, 12'h258, 32'h8);
    apb(0, 12'h200, 0);
    chk("insel_read", 32'h3, prd);
    pin <= 32'h0000_0008;
    repeat (4) @(posedge clk_in);
    chk("in_pick", 32'h1, {31'h0, pio[0]});
    pin <= 32'hffff_fff7;
    repeat (4) @(posedge clk_in);
    chk("in_other", 32'h0, {31'h0, pio[0]});
    chk("in_beyond", 32'h0, {31'h0, pio[22]});
    $display("test input done");
  endtask
  task automatic t_lock;
    set_lock(1);
    chk("lock", 32'h1, {31'h0, lock});
    apb(1, 12'h114, 32'h2);
    chk("silent", 32'h0, {31'h0, perr});
    apb(0, 12'h114, 0);
    chk("kept", 32'h0, prd);
    set_lock(0);
    apb(0, 12'h000, 0);
    chk("sealed", 32'h1, {31'h0, prd[13]});
    apb(1, 12'h114, 32'h2);
    apb(0, 12'h114, 0);
    chk("frozen", 32'h0, prd);
    apb(0, 12'h260, 0);
    chk("unmapped", 32'h1, {31'h0, perr});
    // Strap now programmed for many sessions; it is caught again after reset
    ss <= 0;
    rst <= 1;
    repeat (2) @(posedge clk_in);
    rst <= 0;
    @(posedge clk_in);
    chk("lock_rst", 32'h0, {31'h0, lock});
    apb(1, 12'h114, 32'h2);
    apb(0, 12'h114, 0);
    chk("reopen", 32'h2, prd);
    chk("session_off", 32'h0, {31'h0, ssq});
    apb(1, 12'h000, 32'h0000_2000);
    chk("no_keys", 32'h0, {31'h0, lock});
    set_lock(1);
    chk("relock", 32'h1, {31'h0, lock});
    set_lock(0);
    chk("free_clear", 32'h0, {31'h0, lock});
    $display("test lock done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence: 16-cycle reset, let the strap capture settle
  initial begin
    repeat (16) @(posedge clk_in);
    rst <= 0;
    repeat (3) @(posedge clk_in);
    t_reset;
    t_route;
    t_input;
    t_lock;
    print_verdict;
  end
endmodule // testbench
